// File: verilog/pll_feedback_divider.sv
`timescale 1ns/1ns
module pll_feedback_divider (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        osc_in,
  input  wire logic        ref_in,
  input  wire logic        tune_low,
  output logic             div_out,
  output logic             pd_out,
  output logic             pd_oe_n,
  output logic             guard_charge,
  output logic             range_a,
  output logic             range_b,
  output logic             band_hi,
  output logic             half_div
);

  localparam int SW = fbdiv_pkg::STAGE_W;
  localparam int NS = fbdiv_pkg::STAGES;

  logic [11:0]   factor_reg;
  logic [3:0]    ctrl_reg;
  logic [SW-1:0] stage_reg [NS];
  logic [SW-1:0] stage_next [NS];
  logic          load_ff_reg;
  logic          load_ff_next;
  logic          osc_q_reg;
  logic          ref_q_reg;
  logic [31:0]   prdata_reg;
  logic          pready_reg;
  logic          pslverr_reg;
  logic          div_out_reg;
  logic          pd_out_reg;
  logic          pd_oe_n_reg;
  logic          guard_reg;
  logic [3:0]    ctrl_out_reg;

  pd_if pdc ();

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire        setup_ph   = psel && !penable;
  wire        access_ph  = psel && penable && pready_reg;
  wire        hit_factor = (paddr == fbdiv_pkg::ADDR_FACTOR);
  wire        hit_ctrl   = (paddr == fbdiv_pkg::ADDR_CTRL);
  wire        hit_status = (paddr == fbdiv_pkg::ADDR_STATUS);
  wire        mapped     = hit_factor || hit_ctrl || hit_status;
  wire        wr_factor  = access_ph && pwrite && hit_factor;
  wire        wr_ctrl    = access_ph && pwrite && hit_ctrl;
  wire [11:0] count_all  = {stage_reg[2], stage_reg[1], stage_reg[0]};

  wire [31:0] status_word = {16'h0000, guard_reg, pdc.dn, pdc.up,
                             load_ff_reg, count_all};
  wire [31:0] rd_mux =
      hit_factor ? {20'h00000, factor_reg} :
      hit_ctrl   ? {28'h0000000, ctrl_reg} :
      hit_status ? status_word : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      factor_reg <= fbdiv_pkg::FACTOR_RST;
      ctrl_reg   <= fbdiv_pkg::CTRL_RST;
    end else begin
      if (wr_factor)
        factor_reg <= pwdata[11:0];
      if (wr_ctrl)
        ctrl_reg <= pwdata[3:0];
    end
  end

  // No wait state: answer prepared during setup, ready in the first access cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end else begin
      pready_reg  <= setup_ph;
      pslverr_reg <= setup_ph && !mapped;
      if (setup_ph)
        prdata_reg <= pwrite ? 32'h00000000 : rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input edges
  wire osc_rise = osc_in && !osc_q_reg;
  wire ref_rise = ref_in && !ref_q_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_q_reg <= 1'b0;
      ref_q_reg <= 1'b0;
    end else begin
      osc_q_reg <= osc_in;
      ref_q_reg <= ref_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Down-counter stages
  logic [NS:0]   borrow_in;
  logic [NS-1:0] stage_zero;
  logic [NS-1:0] borrow_n;

  assign borrow_in[0] = 1'b1;

  genvar i;
  generate
    for (i = 0; i < NS; i++) begin : g_stage
      assign stage_zero[i]  = (stage_reg[i] == '0);
      assign borrow_in[i+1] = borrow_in[i] && stage_zero[i];
      // low while stage empty and count high
      assign borrow_n[i]    = !(stage_zero[i] && osc_in);
      always_comb begin
        stage_next[i] = stage_reg[i];
        if (osc_rise) begin
          if (!load_ff_reg)
            stage_next[i] = factor_reg[i*SW +: SW];
          else if (borrow_in[i])
            stage_next[i] = stage_reg[i] - 4'h1;
        end
      end
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
          stage_reg[i] <= '0;
        else
          stage_reg[i] <= stage_next[i];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Reload decode and load flip-flop
  // OR of upper borrows and low-stage bits 0, 2, 3
  // Borrows read at a count rise, while the count pulse is high
  wire upper_hold = borrow_n[1] | borrow_n[2];
  wire reload_d   = upper_hold | stage_reg[0][0] |
                    stage_reg[0][2] | stage_reg[0][3];

  always_comb begin
    load_ff_next = load_ff_reg;
    if (osc_rise) begin
      load_ff_next = load_ff_reg ? reload_d : 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      load_ff_reg <= 1'b1;
    else
      load_ff_reg <= load_ff_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase detector
  assign pdc.sig_rise = !load_ff_reg && load_ff_next;
  assign pdc.ref_rise = ref_rise;

  phase_detector u_pd (
    .clk   (clk),
    .rst_n (rst_n),
    .pd    (pdc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_out_reg  <= 1'b1;
      pd_out_reg   <= 1'b0;
      pd_oe_n_reg  <= 1'b1;
      guard_reg    <= 1'b0;
      ctrl_out_reg <= fbdiv_pkg::CTRL_RST;
    end else begin
      div_out_reg  <= load_ff_next;
      pd_out_reg   <= pdc.up;
      pd_oe_n_reg  <= !(pdc.up || pdc.dn);
      guard_reg    <= tune_low;
      ctrl_out_reg <= ctrl_reg;
    end
  end

  assign prdata       = prdata_reg;
  assign pready       = pready_reg;
  assign pslverr      = pslverr_reg;
  assign div_out      = div_out_reg;
  assign pd_out       = pd_out_reg;
  assign pd_oe_n      = pd_oe_n_reg;
  assign guard_charge = guard_reg;
  assign range_a      = ctrl_out_reg[fbdiv_pkg::CTRL_RANGE_A];
  assign range_b      = ctrl_out_reg[fbdiv_pkg::CTRL_RANGE_B];
  assign band_hi      = ctrl_out_reg[fbdiv_pkg::CTRL_BAND_HI];
  assign half_div     = ctrl_out_reg[fbdiv_pkg::CTRL_HALF];

endmodule : pll_feedback_divider

// File: verilog/fbdiv_pkg.sv
package fbdiv_pkg;

  // Register map (byte addresses)
  localparam logic [7:0]  ADDR_FACTOR  = 8'h00;
  localparam logic [7:0]  ADDR_CTRL    = 8'h04;
  localparam logic [7:0]  ADDR_STATUS  = 8'h08;

  // Divider geometry
  localparam int          STAGES       = 3;
  localparam int          STAGE_W      = 4;
  localparam int          FACTOR_W     = 12;

  // Reset values
  localparam logic [11:0] FACTOR_RST   = 12'h064;
  localparam logic [3:0]  CTRL_RST     = 4'h0;

  // Control register fields
  localparam int          CTRL_RANGE_A = 0;
  localparam int          CTRL_RANGE_B = 1;
  localparam int          CTRL_BAND_HI = 2;
  localparam int          CTRL_HALF    = 3;

  // Status register fields
  localparam int          ST_COUNT_LSB = 0;
  localparam int          ST_LOAD_FF   = 12;
  localparam int          ST_PD_UP     = 13;
  localparam int          ST_PD_DN     = 14;
  localparam int          ST_GUARD     = 15;

  // Loop guard levels, millivolts
  localparam int          GUARD_TRIP_MV = 4000;
  localparam int          GUARD_MAX_MV  = 25000;

  // Phase detector states
  typedef enum logic [2:0] {
    PD_IDLE = 3'b001,
    PD_UP   = 3'b010,
    PD_DN   = 3'b100
  } pd_state_t;

endpackage : fbdiv_pkg

// File: verilog/pd_if.sv
`timescale 1ns/1ns
interface pd_if;
  logic sig_rise;
  logic ref_rise;
  logic up;
  logic dn;
  modport ctl (output sig_rise, output ref_rise, input up, input dn);
  modport det (input sig_rise, input ref_rise, output up, output dn);
endinterface : pd_if

// File: verilog/phase_detector.sv
`timescale 1ns/1ns
module phase_detector (
  input  wire logic clk,
  input  wire logic rst_n,
  pd_if.det         pd
);

  fbdiv_pkg::pd_state_t state_reg;
  fbdiv_pkg::pd_state_t state_next;

  ////////////////////////////////////////////////////////////////////////////
  // rising edges only
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      fbdiv_pkg::PD_IDLE: begin
        if (pd.ref_rise && !pd.sig_rise)
          state_next = fbdiv_pkg::PD_UP;
        else if (pd.sig_rise && !pd.ref_rise)
          state_next = fbdiv_pkg::PD_DN;
      end
      fbdiv_pkg::PD_UP: begin
        if (pd.sig_rise)
          state_next = fbdiv_pkg::PD_IDLE;
      end
      fbdiv_pkg::PD_DN: begin
        if (pd.ref_rise)
          state_next = fbdiv_pkg::PD_IDLE;
      end
      default: state_next = fbdiv_pkg::PD_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      state_reg <= fbdiv_pkg::PD_IDLE;
    else
      state_reg <= state_next;
  end

  assign pd.up = (state_reg == fbdiv_pkg::PD_UP);
  assign pd.dn = (state_reg == fbdiv_pkg::PD_DN);

endmodule : phase_detector

// File: verif/pll_fb_monitor.sv
`timescale 1ns/1ns
module pll_fb_monitor (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        tune_low,
  input wire logic        div_out,
  input wire logic        guard_charge,
  input wire logic        range_a,
  input wire logic        range_b,
  input wire logic        band_hi,
  input wire logic        half_div
);
  wire logic [3:0] ctrl_out = {half_div, band_hi, range_b, range_a};
  wire logic       mapped   = paddr inside {8'h00, 8'h04, 8'h08};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_ready_answer:
    assert property (psel && !penable |=> pready) else $error("no ready");
  a_ready_pulse:
    assert property (pready |=> !pready) else $error("ready too long");
  a_err_unmapped:
    assert property (pready |-> pslverr == !mapped) else $error("bad slverr");
  a_err_with_ready:
    assert property (pslverr |-> pready) else $error("slverr alone");
  a_ctrl_follow:
    assert property (psel && penable && pready && pwrite && paddr == 8'h04
      |-> ##2 ctrl_out == $past(pwdata[3:0], 2)) else $error("ctrl lost");
  a_guard_rise:
    assert property ($rose(tune_low) |=> guard_charge) else $error("no guard");
  a_guard_fall:
    assert property ($fell(tune_low) |=> !guard_charge) else $error("guard");
  a_div_low_short:
    assert property ($fell(div_out) |-> ##[1:8] $rose(div_out))
      else $error("div low too long");
  a_div_high_run:
    assert property ($rose(div_out) |-> div_out[*6]) else $error("div short");
endmodule : pll_fb_monitor
bind pll_feedback_divider pll_fb_monitor mon_u (
  .clk          (clk),
  .rst_n        (rst_n),
  .psel         (psel),
  .penable      (penable),
  .pwrite       (pwrite),
  .paddr        (paddr),
  .pwdata       (pwdata),
  .pready       (pready),
  .pslverr      (pslverr),
  .tune_low     (tune_low),
  .div_out      (div_out),
  .guard_charge (guard_charge),
  .range_a      (range_a),
  .range_b      (range_b),
  .band_hi      (band_hi),
  .half_div     (half_div)
);

// File: verif/apb_ctl.sv
`timescale 1ns/1ns
module apb_ctl (
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : apb_ctl

// File: verif/pll_feedback_divider_test.sv
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
  $display("[FAIL] %0t %h %h", $time, (a), (b)); end end
module pll_feedback_divider_test;
  logic        clk = 1'b0, rst_n = 1'b0, osc_in = 1'b0;
  logic        ref_in = 1'b0, tune_low = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, div_out, pd_out;
  logic        pd_oe_n, guard_charge, range_a, range_b, band_hi, half_div;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  ph = 2'h0;
  int          fails = 0, total_checks = 0, cyc = 0;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    ph <= ph + 2'h1;
    osc_in <= ph[1];
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      test_done();
    end
  end
  apb_ctl ctl_u (
    .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr)
  );
  pll_feedback_divider dut_u (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .osc_in(osc_in), .ref_in(ref_in),
    .tune_low(tune_low), .div_out(div_out), .pd_out(pd_out),
    .pd_oe_n(pd_oe_n), .guard_charge(guard_charge), .range_a(range_a),
    .range_b(range_b), .band_hi(band_hi), .half_div(half_div)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done
  task automatic wait_div(input logic v);
    while (div_out !== ~v) @(posedge clk);
    while (div_out !== v) @(posedge clk);
  endtask : wait_div
  task automatic t_regs;
    logic [31:0] rd;
    logic        er;
    ctl_u.xfer(1'b0, fbdiv_pkg::ADDR_FACTOR, 32'h0, rd, er);
    `CHK(rd, {20'h0, fbdiv_pkg::FACTOR_RST})
    ctl_u.xfer(1'b0, 8'h0c, 32'h0, rd, er);
    `CHK({er, rd}, 33'h1_0000_0000)
    for (int i = 0; i < 16; i++) begin
      ctl_u.xfer(1'b1, fbdiv_pkg::ADDR_CTRL, 32'(i), rd, er);
      repeat (2) @(posedge clk);
      `CHK({half_div, band_hi, range_b, range_a}, 4'(i))
    end
  endtask : t_regs
  task automatic t_guard;
    tune_low <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(guard_charge, 1'b1)
    tune_low <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(guard_charge, 1'b0)
  endtask : t_guard
  task automatic t_period(input logic [11:0] f);
    logic [31:0] rd;
    logic        er;
    int          n;
    int          lo;
    ctl_u.xfer(1'b1, fbdiv_pkg::ADDR_FACTOR, {20'h0, f}, rd, er);
    ctl_u.xfer(1'b0, fbdiv_pkg::ADDR_FACTOR, 32'h0, rd, er);
    `CHK(rd[11:0], f)
    wait_div(1'b0);
    wait_div(1'b0);
    n = 0;
    lo = 0;
    while (div_out !== 1'b1) begin
      @(posedge clk);
      n++;
      lo++;
    end
    while (div_out !== 1'b0) begin
      @(posedge clk);
      n++;
    end
    `CHK(lo, 4)
    `CHK(n, 4 * int'(f))
  endtask : t_period
  task automatic t_pd;
    logic [31:0] rd;
    logic        er;
    wait_div(1'b1);
    repeat (3) @(posedge clk);
    `CHK({pd_oe_n, pd_out}, 2'b00)
    ref_in <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(pd_oe_n, 1'b1)
    ref_in <= 1'b0;
    @(posedge clk);
    ref_in <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK({pd_oe_n, pd_out}, 2'b01)
    ctl_u.xfer(1'b0, fbdiv_pkg::ADDR_STATUS, 32'h0, rd, er);
    `CHK({er, rd[31:12]}, 21'h000003)
    wait_div(1'b1);
    repeat (3) @(posedge clk);
    `CHK(pd_oe_n, 1'b1)
  endtask : t_pd
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_guard();
    t_period(12'h003);
    t_period(12'h213);
    t_pd();
    test_done();
  end
endmodule : pll_feedback_divider_test
